// ==== oms_clk_src.sv ====
`timescale 1ns/100ps
`default_nettype none

module oms_clk_src (
    input wire logic ref_clk_i,
    input wire logic run_i,
    output logic clk_o
);
    logic [2:0] cnt_ff;
    // A stopped source leaves the pin low, as a halted oscillator would.
    always_ff @(posedge ref_clk_i) begin
        cnt_ff <= run_i ? cnt_ff + 3'h1 : 3'h0;
        clk_o <= run_i & cnt_ff[2];
    end
endmodule

`default_nettype wire

// ==== oms_osc_select.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "oms_params.svh"

module oms_osc_select #(
    parameter int OST_TICKS = `OMS_OST_TICKS,
    parameter int SYS_CLK_KHZ = `OMS_REF_CLK_KHZ
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cfg_load_i,
    input wire logic [3:0] clock_source_code_i,
    input wire logic [2:0] internal_freq_choice_i,
    input wire logic multiplier_enable_bit_i,
    input wire logic low_freq_src_fast_i,
    input wire logic power_up_timer_en_i,
    input wire logic fail_safe_monitor_en_i,
    input wire logic watchdog_en_i,
    input wire logic two_speed_start_en_i,
    input wire logic sleep_exit_i,
    input wire logic fast_osc_i,
    input wire logic slow_osc_i,
    input wire logic primary_clock_pin_in_i,
    output logic primary_clock_pin_in_o,
    output logic primary_clock_pin_in_oe_n_o,
    input wire logic primary_clock_pin_out_i,
    output logic primary_clock_pin_out_o,
    output logic primary_clock_pin_out_oe_n_o,
    input wire logic port_bit_six_i,
    input wire logic port_bit_six_oe_n_i,
    output logic port_bit_six_o,
    input wire logic port_bit_seven_i,
    input wire logic port_bit_seven_oe_n_i,
    output logic port_bit_seven_o,
    output oms_pkg::oms_mode_t osc_mode_o,
    output logic cfg_loaded_o,
    output logic crystal_pins_reserved_o,
    output logic osc_startup_wait_o,
    output logic xtal_mult_on_o,
    output logic int_mult_on_o,
    output logic multiplier_enable_bit_o,
    output logic fast_internal_enable_o,
    output logic slow_internal_enable_o,
    output logic sys_clk_tick_o
);
    generate
        if (OST_TICKS < 1 || OST_TICKS > 65535) begin : g_chk_ost
            $error("oms_osc_select: OST_TICKS out of range.");
        end
        if (`OMS_XTAL_IN_MAX_KHZ * `OMS_MULT_FACTOR != `OMS_XTAL_MULT_MAX_KHZ ||
            SYS_CLK_KHZ > `OMS_XTAL_MULT_MAX_KHZ) begin : g_chk_xtal
            $error("oms_osc_select: clock rate above the multiplied crystal limit.");
        end
        if (`OMS_FAST_INT_KHZ * `OMS_MULT_FACTOR != `OMS_INT_MULT_MAX_KHZ ||
            `OMS_POST_MAX_KHZ * 2 != `OMS_FAST_INT_KHZ ||
            `OMS_POST_MIN_KHZ != `OMS_SLOW_INT_KHZ ||
            `OMS_FAST_EN_MIN_KHZ * 64 != `OMS_FAST_INT_KHZ) begin : g_chk_int
            $error("oms_osc_select: internal clock table inconsistent.");
        end
    endgenerate
    function automatic oms_pkg::oms_mode_t oms_decode(input logic [3:0] code);
        oms_pkg::oms_mode_t m;
        case (code)
            `OMS_CODE_CRYSTAL_LOW_POWER: m = oms_pkg::MODE_CRYSTAL_LOW_POWER;
            `OMS_CODE_CRYSTAL_RESONATOR: m = oms_pkg::MODE_CRYSTAL_RESONATOR;
            `OMS_CODE_HIGH_SPEED_CRYSTAL: m = oms_pkg::MODE_HIGH_SPEED_CRYSTAL;
            `OMS_CODE_CRYSTAL_TIMES_FOUR: m = oms_pkg::MODE_CRYSTAL_TIMES_FOUR;
            `OMS_CODE_RES_CAP_IO: m = oms_pkg::MODE_RES_CAP_IO;
            `OMS_CODE_INTERNAL_QUARTER: m = oms_pkg::MODE_INTERNAL_QUARTER_OUT;
            `OMS_CODE_INTERNAL_BOTH_IO: m = oms_pkg::MODE_INTERNAL_BOTH_IO;
            `OMS_CODE_EXT_CLOCK_QUARTER: m = oms_pkg::MODE_EXT_CLOCK_QUARTER_OUT;
            `OMS_CODE_EXT_CLOCK_IO: m = oms_pkg::MODE_EXT_CLOCK_IO;
            default: m = oms_pkg::MODE_RES_CAP_QUARTER_OUT;
        endcase
        return m;
    endfunction
    function automatic logic oms_is_crystal(input oms_pkg::oms_mode_t m);
        return (m == oms_pkg::MODE_CRYSTAL_LOW_POWER) || (m == oms_pkg::MODE_CRYSTAL_RESONATOR) ||
               (m == oms_pkg::MODE_HIGH_SPEED_CRYSTAL) || (m == oms_pkg::MODE_CRYSTAL_TIMES_FOUR);
    endfunction
    function automatic logic oms_is_internal(input oms_pkg::oms_mode_t m);
        return (m == oms_pkg::MODE_INTERNAL_QUARTER_OUT) || (m == oms_pkg::MODE_INTERNAL_BOTH_IO);
    endfunction
    // Pin and oscillator levels: bit 0 input pin, 1 output pin, 2 fast, 3 slow.
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] sync3_ff;
    logic [3:0] acc_ff;
    logic [3:0] acc_d_ff;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            sync3_ff <= 4'h0;
        end else begin
            sync1_ff <= {slow_osc_i, fast_osc_i, primary_clock_pin_out_i, primary_clock_pin_in_i};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end
    // A level is accepted only once the second and third stages agree.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            acc_ff <= 4'h0;
            acc_d_ff <= 4'h0;
        end else begin
            acc_ff <= (sync2_ff & sync3_ff) | (acc_ff & (sync2_ff | sync3_ff));
            acc_d_ff <= acc_ff;
        end
    end
    wire logic [3:0] rise = acc_ff & ~acc_d_ff;
    oms_pkg::oms_cfg_state_t cfg_state_ff;
    oms_pkg::oms_cfg_state_t nxt_cfg_state;
    oms_pkg::oms_mode_t mode_ff;
    wire oms_pkg::oms_mode_t dec_mode = oms_decode(clock_source_code_i);
    wire logic run = (cfg_state_ff == oms_pkg::CFG_RUN);
    always_comb begin
        nxt_cfg_state = cfg_state_ff;
        case (cfg_state_ff)
            oms_pkg::CFG_WAIT: begin
                if (cfg_load_i) begin
                    nxt_cfg_state = oms_pkg::CFG_RUN;
                end
            end
            oms_pkg::CFG_RUN: begin
                nxt_cfg_state = oms_pkg::CFG_RUN;
            end
            default: begin
                nxt_cfg_state = oms_pkg::CFG_WAIT;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg_state_ff <= oms_pkg::CFG_WAIT;
            mode_ff <= oms_pkg::MODE_INTERNAL_BOTH_IO;
        end else begin
            cfg_state_ff <= nxt_cfg_state;
            if (cfg_load_i) begin
                mode_ff <= dec_mode;
            end
        end
    end
    wire logic is_xtal = oms_is_crystal(mode_ff);
    wire logic is_int = oms_is_internal(mode_ff);
    wire logic m_times_four = (mode_ff == oms_pkg::MODE_CRYSTAL_TIMES_FOUR);
    wire logic int_freq_fast = (internal_freq_choice_i == `OMS_IFC_FAST_DIRECT) ||
                               (internal_freq_choice_i == `OMS_IFC_FAST_HALF);
    wire logic int_mult_avail = run && is_int && int_freq_fast;
    wire logic low_sel = (internal_freq_choice_i == `OMS_IFC_LOW_FREQ);
    wire logic quarter_out = (mode_ff == oms_pkg::MODE_EXT_CLOCK_QUARTER_OUT) ||
                             (mode_ff == oms_pkg::MODE_RES_CAP_QUARTER_OUT) ||
                             (mode_ff == oms_pkg::MODE_INTERNAL_QUARTER_OUT);
    wire logic six_io = (mode_ff == oms_pkg::MODE_EXT_CLOCK_IO) ||
                        (mode_ff == oms_pkg::MODE_RES_CAP_IO) ||
                        (mode_ff == oms_pkg::MODE_INTERNAL_BOTH_IO);
    // Start-up wait counts edges of the crystal on the input pin.
    logic [`OMS_OST_W-1:0] ost_cnt_ff;
    localparam logic [`OMS_OST_W-1:0] OST_LOAD = OST_TICKS[`OMS_OST_W-1:0];
    wire logic ost_start_load = cfg_load_i && oms_is_crystal(dec_mode);
    wire logic ost_start_wake = sleep_exit_i && run && is_xtal;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ost_cnt_ff <= '0;
        end else if (ost_start_load || ost_start_wake) begin
            ost_cnt_ff <= OST_LOAD;
        end else if (cfg_load_i || !is_xtal) begin
            ost_cnt_ff <= '0;
        end else if (rise[0] && ost_cnt_ff != '0) begin
            ost_cnt_ff <= ost_cnt_ff - {{(`OMS_OST_W-1){1'b0}}, 1'b1};
        end
    end
    logic post_tick;
    oms_postscaler #(
        .CNT_W(8)
    ) u_post (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .fast_tick_i(rise[2]),
        .slow_tick_i(rise[3]),
        .freq_choice_i(internal_freq_choice_i),
        .low_src_fast_i(low_freq_src_fast_i),
        .tick_o(post_tick)
    );
    // Crystal, RC and external clock all arrive on the input pin.
    wire logic nxt_sys_tick = run && (is_int ? post_tick : rise[0]);
    logic sys_tick_ff;
    logic quarter_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sys_tick_ff <= 1'b0;
        end else begin
            sys_tick_ff <= nxt_sys_tick;
        end
    end
    oms_quarter_div #(
        .DIV_W(2)
    ) u_quarter (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tick_i(sys_tick_ff),
        .q_o(quarter_q)
    );
    wire logic nxt_out_pin = quarter_out ? quarter_q : (six_io ? port_bit_six_i : 1'b0);
    wire logic nxt_out_oe_n = !run || is_xtal || (six_io ? port_bit_six_oe_n_i : !quarter_out);
    wire logic nxt_in_pin = is_int ? port_bit_seven_i : 1'b0;
    wire logic nxt_in_oe_n = !(run && is_int) || port_bit_seven_oe_n_i;
    wire logic nxt_six_rd = run && six_io && acc_ff[1];
    wire logic nxt_seven_rd = run && is_int && acc_ff[0];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            primary_clock_pin_out_o <= 1'b0;
            primary_clock_pin_out_oe_n_o <= 1'b1;
            primary_clock_pin_in_o <= 1'b0;
            primary_clock_pin_in_oe_n_o <= 1'b1;
            port_bit_six_o <= 1'b0;
            port_bit_seven_o <= 1'b0;
        end else begin
            primary_clock_pin_out_o <= nxt_out_pin;
            primary_clock_pin_out_oe_n_o <= nxt_out_oe_n;
            primary_clock_pin_in_o <= nxt_in_pin;
            primary_clock_pin_in_oe_n_o <= nxt_in_oe_n;
            port_bit_six_o <= nxt_six_rd;
            port_bit_seven_o <= nxt_seven_rd;
        end
    end
    wire logic nxt_xtal_mult = run && m_times_four;
    wire logic nxt_int_mult = int_mult_avail && multiplier_enable_bit_i;
    wire logic nxt_fast_en = run && is_int && (!low_sel || low_freq_src_fast_i);
    wire logic nxt_slow_en = (run && is_int && low_sel && !low_freq_src_fast_i) ||
                             power_up_timer_en_i || fail_safe_monitor_en_i ||
                             watchdog_en_i || two_speed_start_en_i;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            xtal_mult_on_o <= 1'b0;
            int_mult_on_o <= 1'b0;
            fast_internal_enable_o <= 1'b0;
            slow_internal_enable_o <= 1'b0;
        end else begin
            xtal_mult_on_o <= nxt_xtal_mult;
            int_mult_on_o <= nxt_int_mult;
            fast_internal_enable_o <= nxt_fast_en;
            slow_internal_enable_o <= nxt_slow_en;
        end
    end
    assign multiplier_enable_bit_o = int_mult_on_o;
    assign osc_mode_o = mode_ff;
    assign cfg_loaded_o = run;
    assign crystal_pins_reserved_o = run && is_xtal;
    assign osc_startup_wait_o = (ost_cnt_ff != '0);
    assign sys_clk_tick_o = sys_tick_ff;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_load_crystal;
        cfg_load_i && oms_is_crystal(dec_mode);
    endsequence
    sequence s_wait_running;
        osc_startup_wait_o [*2];
    endsequence
    a_ost_crystal: assert property (s_load_crystal |=> s_wait_running)
        else $error("Crystal load did not start the start-up wait.");
    a_ost_ext_clock: assert property (cfg_load_i &&
        (clock_source_code_i == `OMS_CODE_EXT_CLOCK_QUARTER ||
         clock_source_code_i == `OMS_CODE_EXT_CLOCK_IO) |=> !osc_startup_wait_o)
        else $error("External clock mode applied a start-up wait.");
    a_mode_hold: assert property (run && !cfg_load_i |=> $stable(mode_ff))
        else $error("Mode changed without a configuration load.");
    a_xtal_mult_code: assert property (xtal_mult_on_o |->
        $past(mode_ff) == oms_pkg::MODE_CRYSTAL_TIMES_FOUR)
        else $error("Crystal multiplier on outside times-four mode.");
    a_xtal_mult_on: assert property (run && m_times_four |=> xtal_mult_on_o)
        else $error("Times-four mode did not enable the multiplier.");
    a_int_mult_cond: assert property (int_mult_on_o |->
        $past(is_int) && $past(int_freq_fast) && $past(multiplier_enable_bit_i))
        else $error("Internal multiplier on without its conditions.");
    a_mult_forced_zero: assert property (!int_mult_avail |=> !multiplier_enable_bit_o)
        else $error("Multiplier enable read back set where unavailable.");
    a_pins_reserved: assert property (run && is_xtal |=>
        primary_clock_pin_out_oe_n_o && primary_clock_pin_in_oe_n_o)
        else $error("Crystal pins driven in a crystal mode.");
    a_six_io_pass: assert property (run && six_io |=>
        primary_clock_pin_out_o == $past(port_bit_six_i))
        else $error("Port bit six not passed to the output pin.");
    a_quarter_drive: assert property (run && quarter_out |=>
        !primary_clock_pin_out_oe_n_o && primary_clock_pin_out_o == $past(quarter_q))
        else $error("Quarter clock not driven on the output pin.");
    a_seven_io_pass: assert property (run && is_int && !port_bit_seven_oe_n_i |=>
        !primary_clock_pin_in_oe_n_o && primary_clock_pin_in_o == $past(port_bit_seven_i))
        else $error("Port bit seven not driven in an internal mode.");
    a_slow_features: assert property (watchdog_en_i || power_up_timer_en_i |=>
        slow_internal_enable_o)
        else $error("Slow internal clock off while a timing feature is on.");
    a_fast_range: assert property (run && is_int && !low_sel |=> fast_internal_enable_o)
        else $error("Fast internal clock off for a selected frequency.");

endmodule

`default_nettype wire

// ==== oms_params.svh ====
`ifndef OMS_PARAMS_SVH
`define OMS_PARAMS_SVH

// Clock source codes held in nonvolatile configuration.
`define OMS_CODE_CRYSTAL_LOW_POWER 4'h0
`define OMS_CODE_CRYSTAL_RESONATOR 4'h1
`define OMS_CODE_HIGH_SPEED_CRYSTAL 4'h2
`define OMS_CODE_RES_CAP_QUARTER 4'h3
`define OMS_CODE_EXT_CLOCK_QUARTER 4'h4
`define OMS_CODE_EXT_CLOCK_IO 4'h5
`define OMS_CODE_CRYSTAL_TIMES_FOUR 4'h6
`define OMS_CODE_RES_CAP_IO 4'h7
`define OMS_CODE_INTERNAL_BOTH_IO 4'h8
`define OMS_CODE_INTERNAL_QUARTER 4'h9

// Internal frequency choice field values.
`define OMS_IFC_FAST_DIRECT 3'h7
`define OMS_IFC_FAST_HALF 3'h6
`define OMS_IFC_LOW_FREQ 3'h0
`define OMS_IFC_BASE_SHIFT 3'h7
`define OMS_POST_FULL_MASK 8'hff

// Frequencies in kHz.
`define OMS_REF_CLK_KHZ 40000
`define OMS_XTAL_IN_MAX_KHZ 10000
`define OMS_MULT_FACTOR 4
`define OMS_XTAL_MULT_MAX_KHZ 40000
`define OMS_INT_MULT_MAX_KHZ 32000
`define OMS_FAST_INT_KHZ 8000
`define OMS_POST_MAX_KHZ 4000
`define OMS_POST_MIN_KHZ 31
`define OMS_FAST_EN_MIN_KHZ 125
`define OMS_SLOW_INT_KHZ 31

// Oscillator start-up wait, in oscillator edges.
`define OMS_OST_TICKS 1024
`define OMS_OST_W 16

`endif

// ==== oms_pkg.sv ====
package oms_pkg;

    typedef enum logic [9:0] {
        MODE_CRYSTAL_LOW_POWER = 10'h001,
        MODE_CRYSTAL_RESONATOR = 10'h002,
        MODE_HIGH_SPEED_CRYSTAL = 10'h004,
        MODE_CRYSTAL_TIMES_FOUR = 10'h008,
        MODE_RES_CAP_QUARTER_OUT = 10'h010,
        MODE_RES_CAP_IO = 10'h020,
        MODE_INTERNAL_QUARTER_OUT = 10'h040,
        MODE_INTERNAL_BOTH_IO = 10'h080,
        MODE_EXT_CLOCK_QUARTER_OUT = 10'h100,
        MODE_EXT_CLOCK_IO = 10'h200
    } oms_mode_t;

    typedef enum logic [1:0] {
        CFG_WAIT = 2'h1,
        CFG_RUN = 2'h2
    } oms_cfg_state_t;

endpackage

// ==== oms_postscaler.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "oms_params.svh"

module oms_postscaler #(
    parameter int CNT_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic fast_tick_i,
    input wire logic slow_tick_i,
    input wire logic [2:0] freq_choice_i,
    input wire logic low_src_fast_i,
    output logic tick_o
);

    generate
        if (CNT_W < 8) begin : g_chk
            $error("oms_postscaler: CNT_W must be at least 8.");
        end
    endgenerate

    function automatic logic [7:0] oms_post_mask(input logic [2:0] choice, input logic lowfast);
        logic [7:0] m;
        m = 8'h00;
        if (choice == `OMS_IFC_LOW_FREQ) begin
            m = lowfast ? `OMS_POST_FULL_MASK : 8'h00;
        end else begin
            m = ~(`OMS_POST_FULL_MASK << (`OMS_IFC_BASE_SHIFT - choice));
        end
        return m;
    endfunction

    logic [CNT_W-1:0] cnt_ff;
    logic tick_ff;
    wire logic [7:0] mask = oms_post_mask(freq_choice_i, low_src_fast_i);
    wire logic use_slow = (freq_choice_i == `OMS_IFC_LOW_FREQ) && !low_src_fast_i;
    wire logic nxt_tick = use_slow ? slow_tick_i
                                   : (fast_tick_i && ((cnt_ff[7:0] & mask) == mask));

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
        end else if (fast_tick_i) begin
            cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= nxt_tick;
        end
    end

    assign tick_o = tick_ff;

endmodule

`default_nettype wire

// ==== oms_quarter_div.sv ====
`timescale 1ns/100ps
`default_nettype none

module oms_quarter_div #(
    parameter int DIV_W = 2
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    output logic q_o
);

    generate
        if (DIV_W < 1) begin : g_chk
            $error("oms_quarter_div: DIV_W must be at least 1.");
        end
    endgenerate

    logic [DIV_W-1:0] cnt_ff;

    // The top bit completes one period every 2**DIV_W tick_i pulses.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
        end else if (tick_i) begin
            cnt_ff <= cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    assign q_o = cnt_ff[DIV_W-1];

endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
$display("wrong value at %0t: %h vs %h", $time, a, b); end end

module tb;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, cfg_load_i = 1'b0, run = 1'b0, mon = 1'b0, seen;
    logic [3:0] clock_source_code_i = 4'h0, feat = 4'h0;
    logic [2:0] internal_freq_choice_i = 3'h7;
    logic multiplier_enable_bit_i = 1'b1, low_freq_src_fast_i = 1'b0, sleep_exit_i = 1'b0;
    logic fast_osc_i = 1'b0, slow_osc_i = 1'b0, src_clk, last_out;
    logic port_bit_six_i = 1'b1, port_bit_six_oe_n_i = 1'b0;
    logic port_bit_seven_i = 1'b1, port_bit_seven_oe_n_i = 1'b0;
    logic primary_clock_pin_in_i, primary_clock_pin_out_i;
    logic primary_clock_pin_in_o, primary_clock_pin_in_oe_n_o, primary_clock_pin_out_o;
    logic primary_clock_pin_out_oe_n_o, port_bit_six_o, port_bit_seven_o, cfg_loaded_o;
    logic crystal_pins_reserved_o, osc_startup_wait_o, xtal_mult_on_o, int_mult_on_o;
    logic multiplier_enable_bit_o, fast_internal_enable_o, slow_internal_enable_o;
    logic sys_clk_tick_o;
    oms_pkg::oms_mode_t osc_mode_o;
    int error_cnt = 0, n_compared = 0, gap, nchg;
    logic [9:0] mode_tab [10] = '{10'h001, 10'h002, 10'h004, 10'h010, 10'h100, 10'h200,
        10'h008, 10'h020, 10'h080, 10'h040};

    always #12.5 ref_clk_i = ~ref_clk_i;
    always #50 fast_osc_i = ~fast_osc_i;
    always #400 slow_osc_i = ~slow_osc_i;
    assign primary_clock_pin_in_i = primary_clock_pin_in_oe_n_o ? src_clk : primary_clock_pin_in_o;
    assign primary_clock_pin_out_i = primary_clock_pin_out_oe_n_o ? 1'b1 : primary_clock_pin_out_o;

    oms_clk_src src (.ref_clk_i, .run_i(run), .clk_o(src_clk));

    oms_osc_select #(.OST_TICKS(4)) dut (.ref_clk_i, .rst_i, .cfg_load_i, .clock_source_code_i,
        .internal_freq_choice_i, .multiplier_enable_bit_i, .low_freq_src_fast_i,
        .power_up_timer_en_i(feat[0]), .fail_safe_monitor_en_i(feat[1]),
        .watchdog_en_i(feat[2]), .two_speed_start_en_i(feat[3]), .sleep_exit_i, .fast_osc_i,
        .slow_osc_i, .primary_clock_pin_in_i, .primary_clock_pin_in_o,
        .primary_clock_pin_in_oe_n_o, .primary_clock_pin_out_i, .primary_clock_pin_out_o,
        .primary_clock_pin_out_oe_n_o, .port_bit_six_i, .port_bit_six_oe_n_i, .port_bit_six_o,
        .port_bit_seven_i, .port_bit_seven_oe_n_i, .port_bit_seven_o, .osc_mode_o,
        .cfg_loaded_o, .crystal_pins_reserved_o, .osc_startup_wait_o, .xtal_mult_on_o,
        .int_mult_on_o, .multiplier_enable_bit_o, .fast_internal_enable_o,
        .slow_internal_enable_o, .sys_clk_tick_o);

    // Quarter output must change once per two system ticks.
    always @(negedge ref_clk_i) begin
        if (!mon) begin
            gap = 0;
            nchg = 0;
            seen = 1'b0;
        end else begin
            if (primary_clock_pin_out_o !== last_out) begin
                if (seen) `CHK(gap, 2)
                seen = 1'b1;
                nchg++;
                gap = 0;
            end
            if (sys_clk_tick_o) gap++;
        end
        last_out = primary_clock_pin_out_o;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic load(input logic [3:0] c);
        @(posedge ref_clk_i);
        cfg_load_i <= 1'b1;
        clock_source_code_i <= c;
        @(posedge ref_clk_i);
        cfg_load_i <= 1'b0;
        step(4);
    endtask

    task automatic pulse_sleep_exit();
        @(posedge ref_clk_i);
        sleep_exit_i <= 1'b1;
        @(posedge ref_clk_i);
        sleep_exit_i <= 1'b0;
        step(2);
    endtask

    task automatic quarter_run(input logic [3:0] c);
        load(c);
        mon = 1'b1;
        step(400);
        `CHK(nchg > 10, 1'b1)
        `CHK(primary_clock_pin_out_oe_n_o, 1'b0)
        mon = 1'b0;
    endtask

    task automatic test_done();
        if (error_cnt == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        #2_000_000;
        error_cnt++;
        test_done();
    end

    initial begin
        step(3);
        rst_i <= 1'b0;
        step(1);
        `CHK(cfg_loaded_o, 1'b0)
        `CHK(primary_clock_pin_out_oe_n_o, 1'b1)
        for (int c = 0; c < 10; c++) begin
            load(c[3:0]);
            `CHK(osc_mode_o, mode_tab[c])
            `CHK(crystal_pins_reserved_o, c inside {0, 1, 2, 6})
            `CHK(osc_startup_wait_o, c inside {0, 1, 2, 6})
            `CHK(xtal_mult_on_o, c == 6)
            `CHK(int_mult_on_o, c >= 8)
            `CHK(multiplier_enable_bit_o, c >= 8)
            `CHK(primary_clock_pin_in_oe_n_o, c < 8)
            if (c inside {5, 7, 8}) `CHK(primary_clock_pin_out_o, 1'b1)
            `CHK(primary_clock_pin_in_o, c >= 8)
            if (c != 5) `CHK(port_bit_six_o, c inside {7, 8})
            if (c != 8) `CHK(port_bit_seven_o, c == 9)
            `CHK(cfg_loaded_o, 1'b1)
        end
        for (int f = 0; f < 8; f++) begin
            internal_freq_choice_i <= f[2:0];
            step(3);
            `CHK(fast_internal_enable_o, f != 0)
            `CHK(slow_internal_enable_o, f == 0)
            `CHK(int_mult_on_o, f >= 6)
            `CHK(multiplier_enable_bit_o, f >= 6)
        end
        internal_freq_choice_i <= 3'h7;
        for (int i = 0; i < 4; i++) begin
            feat <= 4'h1 << i;
            step(3);
            `CHK(slow_internal_enable_o, 1'b1)
        end
        feat <= 4'h0;
        step(3);
        `CHK(slow_internal_enable_o, 1'b0)
        quarter_run(4'h9);
        run <= 1'b1;
        load(4'h2);
        step(80);
        `CHK(osc_startup_wait_o, 1'b0)
        pulse_sleep_exit();
        `CHK(osc_startup_wait_o, 1'b1)
        quarter_run(4'h4);
        quarter_run(4'h3);
        load(4'h4);
        pulse_sleep_exit();
        `CHK(osc_startup_wait_o, 1'b0)
        clock_source_code_i <= 4'h0;
        step(5);
        `CHK(osc_mode_o, mode_tab[4])
        test_done();
    end
endmodule

`default_nettype wire
